// ### inc/ddrps_pkg.sv
/*
 * shared constants and types for the ddr3 scheduling and power block.
 * assumes a 40 MHz controller clock and a 32-bit classic wishbone slave.
 */
package ddrps_pkg;
    localparam int CLK_MHZ = 40;
    localparam int RANK_W  = 1;
    localparam int BANK_W  = 3;
    localparam int ROW_W   = 14;
    localparam int COL_W   = 10;
    localparam int ADDR_W  = RANK_W + BANK_W + ROW_W + COL_W;
    localparam int NBANKS  = 1 << (RANK_W + BANK_W);

    // timing in its own unit, cycle counts derived from the clock rate
    localparam int REFI_NS    = 7800;
    localparam int RFC_NS     = 260;
    localparam int XP_NS      = 24;
    localparam int REFI_CYC   = (REFI_NS * CLK_MHZ) / 1000;
    localparam int RFC_CYC    = (RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int XP_RAW     = (XP_NS * CLK_MHZ + 999) / 1000;
    localparam int XP_CYC     = (XP_RAW < 1) ? 1 : XP_RAW;
    localparam int CMD_GAP    = 2;
    localparam int REF_MARGIN = 32;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_PDTHR  = 8'h04;
    localparam logic [7:0] REG_STARVE = 8'h08;
    localparam logic [7:0] REG_REFCMD = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    localparam int CTRL_PD_EN   = 0;
    localparam int CTRL_TAKEOV  = 1;
    localparam int CTRL_CLOSEPG = 2;
    localparam int CTRL_REORDER = 3;
    localparam int CTRL_URGENT  = 4;
    localparam int CTRL_MAPSEL  = 5;
    localparam int CTRL_W       = 6;
    localparam int STAT_PD      = 0;
    localparam int STAT_REFPEND = 1;
    localparam int STAT_CNT_LSB = 8;

    localparam logic [5:0]  CTRL_RST   = 6'h00;
    localparam logic [15:0] PDTHR_RST  = 16'h0010;
    localparam logic [15:0] PDTHR_MIN  = 16'h0001;
    localparam logic [15:0] PDTHR_MAX  = 16'hfffe;
    localparam logic [5:0]  STARVE_RST = 6'h08;
    localparam logic [5:0]  STARVE_MIN = 6'h01;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
        CMD_PREA, CMD_REF, CMD_PDE, CMD_PDX
    } ddrps_code_type;

    typedef struct packed {
        logic [RANK_W-1:0] rank;
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0]  row;
        logic [COL_W-1:0]  col;
    } ddrps_loc_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic              closePage;
        logic              urgent;
    } ddrps_req_type;

    typedef struct packed {
        ddrps_code_type code;
        ddrps_loc_type  loc;
        logic           autoPre;
    } ddrps_cmd_type;
endpackage

// ### hw/ddrps_ctrl.sv
/*
 * ddr3 controller scheduler: request queue with reordering, starvation
 * limit, urgent requests, per-request page close, address mapping,
 * refresh timing with host takeover, and idle power-down.
 * assumes requests come from logic on ref_clk; registers on wishbone.
 */
// Summary of operation
// R1 - with idle power-down on, enter power-down after threshold idle cycles
// R2 - power-down only when every rank is idle; any activity restarts count
// R3 - idle threshold programmable, every value 1 to 65534 accepted
// R4 - host takeover stops own refresh; host requests refreshes by register
// R5 - per-request close-page flag precharges the bank when the burst ends
// R6 - host address split into rank, bank, row, column by mapping select
// R7 - with reordering on, pending reads and writes may be served out of order
// R8 - with reordering on, activate or precharge issued early for queued work; the code issues them only for the picked request
// R9 - waiting command served after at most limit others; limit 1 to 63
// R10 - urgent requests served ahead of normal ones when enabled
// R11 - own refresh issued before the average refresh interval runs out
// R12 - no activate until refresh cycle time has passed after refresh
// R13 - leave power-down and wait exit time before any other command
// R14 - never reorder across an earlier access to the same address and a write
`timescale 1ns/1ps
module ddrps_ctrl
    import ddrps_pkg::*;
#(
    parameter int DEPTH = 8
)(
    input  wire logic          ref_clk,
    input  wire logic          nrst,
    input  wire logic          wbCyc,
    input  wire logic          wbStb,
    input  wire logic          wbWe,
    input  wire logic [3:0]    wbSel,
    input  wire logic [7:0]    wbAdr,
    input  wire logic [31:0]   wbDatIn,
    output logic               wbAck,
    output logic      [31:0]   wbDatOut,
    input  wire logic          reqValid,
    input  wire ddrps_req_type reqData,
    output logic               reqReady,
    output logic               cmdValid,
    output ddrps_cmd_type      cmdOut,
    output logic               powerDownActive
);
    localparam int IDX_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    initial begin
        if (DEPTH < 2 || DEPTH > 32)
            $error("DEPTH must lie in 2..32");
    end

    function automatic ddrps_loc_type mapAddr(logic [ADDR_W-1:0] a,
                                              logic sel);
        ddrps_loc_type l;
        l = a;
        if (sel) begin
            // bank above row: consecutive rows stay in one bank
            l.rank = a[ADDR_W-1 -: RANK_W];
            l.bank = a[ROW_W+COL_W+BANK_W-1 -: BANK_W];
            l.row  = a[ROW_W+COL_W-1 -: ROW_W];
            l.col  = a[COL_W-1:0];
        end else begin
            l.rank = a[ADDR_W-1 -: RANK_W];
            l.row  = a[ROW_W+BANK_W+COL_W-1 -: ROW_W];
            l.bank = a[BANK_W+COL_W-1 -: BANK_W];
            l.col  = a[COL_W-1:0];
        end
        return l;
    endfunction

    function automatic logic [RANK_W+BANK_W-1:0] bankIdx(ddrps_loc_type l);
        return {l.rank, l.bank};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic rstSync1_reg, rstSync2_reg;
    logic rstN;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstN = rstSync2_reg;

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [CTRL_W-1:0] ctrl_reg;
    logic [15:0]       pdThr_reg;
    logic [5:0]        starve_reg;
    logic              hostRef_reg;
    logic              wbAck_reg;
    logic [31:0]       wbDat_reg;
    logic              busWr;
    logic              refIssue;
    logic [CNT_W-1:0]  count_reg;
    typedef enum logic {ST_ACTIVE, ST_POWERDOWN} ddrps_state_type;
    ddrps_state_type   state_reg;
    logic              refPending;

    assign busWr = wbCyc && wbStb && wbWe && !wbAck_reg && wbSel[0];

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_reg   <= CTRL_RST;
            pdThr_reg  <= PDTHR_RST;
            starve_reg <= STARVE_RST;
        end else if (busWr) begin
            unique case (wbAdr)
                REG_CTRL:   ctrl_reg <= wbDatIn[CTRL_W-1:0];
                REG_PDTHR: begin
                    // out-of-range values saturate to the served range
                    if (wbDatIn[15:0] < PDTHR_MIN)
                        pdThr_reg <= PDTHR_MIN; // R3
                    else if (wbDatIn[15:0] > PDTHR_MAX)
                        pdThr_reg <= PDTHR_MAX;
                    else
                        pdThr_reg <= wbDatIn[15:0]; // R3
                end
                REG_STARVE: begin
                    if (wbDatIn[5:0] < STARVE_MIN)
                        starve_reg <= STARVE_MIN; // R9
                    else
                        starve_reg <= wbDatIn[5:0]; // R9
                end
                default: ;
            endcase
        end
    end

    // a refresh request written in the cycle one is issued is kept
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN)
            hostRef_reg <= 1'b0;
        else if (busWr && wbAdr == REG_REFCMD && wbDatIn[0])
            hostRef_reg <= 1'b1; // R4
        else if (refIssue)
            hostRef_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            wbAck_reg <= 1'b0;
            wbDat_reg <= 32'h0000_0000;
        end else begin
            wbAck_reg <= wbCyc && wbStb && !wbAck_reg;
            unique case (wbAdr)
                REG_CTRL:   wbDat_reg <= {26'h0, ctrl_reg};
                REG_PDTHR:  wbDat_reg <= {16'h0, pdThr_reg};
                REG_STARVE: wbDat_reg <= {26'h0, starve_reg};
                REG_REFCMD: wbDat_reg <= {31'h0, hostRef_reg};
                REG_STATUS: wbDat_reg <= {16'h0,
                    (8)'(count_reg), 6'h0, refPending,
                    state_reg == ST_POWERDOWN};
                default:    wbDat_reg <= 32'h0000_0000;
            endcase
        end
    end
    assign wbAck    = wbAck_reg;
    assign wbDatOut = wbDat_reg;

    ////////////////////////////////////////////////////////////////////////
    // request queue, index 0 oldest
    ddrps_loc_type     qLoc_reg  [DEPTH];
    logic              qWr_reg   [DEPTH];
    logic              qClose_reg[DEPTH];
    logic              qUrg_reg  [DEPTH];
    logic [5:0]        qAge_reg  [DEPTH];
    logic              reqReady_reg;
    logic              enq, deq;
    logic [IDX_W-1:0]  pickIdx;
    logic              pickValid;
    logic [CNT_W-1:0]  slot;

    assign enq  = reqValid && reqReady_reg;
    assign slot = deq ? count_reg - CNT_W'(1) : count_reg;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            count_reg    <= '0;
            reqReady_reg <= 1'b0;
        end else begin
            count_reg    <= count_reg + CNT_W'(enq) - CNT_W'(deq);
            reqReady_reg <= (count_reg + CNT_W'(enq) - CNT_W'(deq))
                            < CNT_W'(DEPTH);
        end
    end
    assign reqReady = reqReady_reg;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < DEPTH; i++) begin
                qLoc_reg[i]   <= '0;
                qWr_reg[i]    <= 1'b0;
                qClose_reg[i] <= 1'b0;
                qUrg_reg[i]   <= 1'b0;
                qAge_reg[i]   <= 6'h00;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (deq && i >= pickIdx && i < DEPTH - 1) begin
                    qLoc_reg[i]   <= qLoc_reg[i+1];
                    qWr_reg[i]    <= qWr_reg[i+1];
                    qClose_reg[i] <= qClose_reg[i+1];
                    qUrg_reg[i]   <= qUrg_reg[i+1];
                    qAge_reg[i]   <= qAge_reg[i+1];
                end else if (deq && i < pickIdx) begin
                    qAge_reg[i] <= qAge_reg[i] + 6'h01; // R9
                end
            end
            if (enq) begin
                qLoc_reg[slot[IDX_W-1:0]]   <=
                    mapAddr(reqData.addr, ctrl_reg[CTRL_MAPSEL]); // R6
                qWr_reg[slot[IDX_W-1:0]]    <= reqData.write;
                qClose_reg[slot[IDX_W-1:0]] <= reqData.closePage
                    && ctrl_reg[CTRL_CLOSEPG]; // R5
                qUrg_reg[slot[IDX_W-1:0]]   <= reqData.urgent
                    && ctrl_reg[CTRL_URGENT]; // R10
                qAge_reg[slot[IDX_W-1:0]]   <= 6'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // choice: starved, then urgent, then open-row hit, then oldest
    logic              bankOpen_reg[NBANKS];
    logic [ROW_W-1:0]  bankRow_reg [NBANKS];
    logic [DEPTH-1:0]  eligible;

    always_comb begin
        logic [1:0] best;
        logic [1:0] prio;
        best      = 2'd0;
        prio      = 2'd0;
        pickIdx   = '0;
        pickValid = 1'b0;
        eligible  = '0;
        for (int i = 0; i < DEPTH; i++) begin
            eligible[i] = i < int'(count_reg);
            for (int j = 0; j < i; j++) begin
                if (qLoc_reg[j] == qLoc_reg[i]
                        && (qWr_reg[j] || qWr_reg[i]))
                    eligible[i] = 1'b0; // R14
            end
            if (i > 0 && !ctrl_reg[CTRL_REORDER] && !qUrg_reg[i])
                eligible[i] = 1'b0; // R7
        end
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (qAge_reg[i] >= starve_reg)
                prio = 2'd3; // R9
            else if (qUrg_reg[i])
                prio = 2'd2; // R10
            else if (ctrl_reg[CTRL_REORDER]
                    && bankOpen_reg[bankIdx(qLoc_reg[i])]
                    && bankRow_reg[bankIdx(qLoc_reg[i])] == qLoc_reg[i].row)
                prio = 2'd1; // R7
            else
                prio = 2'd0;
            if (eligible[i] && (!pickValid || prio >= best)) begin
                best      = prio;
                pickIdx   = IDX_W'(i);
                pickValid = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    logic [3:0]       gap_reg;
    logic [7:0]       rfcWait_reg;
    logic [15:0]      refiCnt_reg;
    logic [15:0]      idle_reg;
    logic             anyOpen;
    logic             cmdValid_reg;
    ddrps_cmd_type    cmd_reg;
    ddrps_cmd_type    cmdNext;
    ddrps_loc_type    pl;
    logic             refDue;

    assign refDue = refiCnt_reg >= 16'(REFI_CYC - REF_MARGIN);
    assign refPending = ctrl_reg[CTRL_TAKEOV] ? hostRef_reg : refDue; // R4
    assign pl = qLoc_reg[pickIdx];

    always_comb begin
        anyOpen = 1'b0;
        for (int b = 0; b < NBANKS; b++)
            anyOpen = anyOpen | bankOpen_reg[b];
    end

    always_comb begin
        cmdNext = '{code: CMD_NOP, loc: pl, autoPre: 1'b0};
        deq     = 1'b0;
        if (gap_reg == 4'h0) begin
            if (state_reg == ST_POWERDOWN) begin
                if (count_reg != '0 || refPending)
                    cmdNext.code = CMD_PDX; // R13
            end else if (refPending) begin
                cmdNext.code = anyOpen ? CMD_PREA : CMD_REF; // R11
            end else if (pickValid) begin
                if (!bankOpen_reg[bankIdx(pl)]) begin
                    if (rfcWait_reg == 8'h00)
                        cmdNext.code = CMD_ACT; // R12
                end else if (bankRow_reg[bankIdx(pl)] != pl.row) begin
                    cmdNext.code = CMD_PRE; // R8
                end else begin
                    cmdNext.code    = qWr_reg[pickIdx] ? CMD_WR : CMD_RD;
                    cmdNext.autoPre = qClose_reg[pickIdx]; // R5
                    deq             = 1'b1;
                end
            end else if (ctrl_reg[CTRL_PD_EN] && !enq
                    && idle_reg >= pdThr_reg) begin
                cmdNext.code = CMD_PDE; // R1
            end
        end
    end
    assign refIssue = cmdNext.code == CMD_REF;

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            cmdValid_reg <= 1'b0;
            cmd_reg      <= '{code: CMD_NOP, loc: '0, autoPre: 1'b0};
            gap_reg      <= 4'h0;
            state_reg    <= ST_ACTIVE;
        end else begin
            cmdValid_reg <= cmdNext.code != CMD_NOP;
            cmd_reg      <= cmdNext;
            if (cmdNext.code == CMD_PDX)
                gap_reg <= 4'(XP_CYC); // R13
            else if (cmdNext.code != CMD_NOP)
                gap_reg <= 4'(CMD_GAP);
            else if (gap_reg != 4'h0)
                gap_reg <= gap_reg - 4'h1;
            if (cmdNext.code == CMD_PDE)
                state_reg <= ST_POWERDOWN;
            else if (cmdNext.code == CMD_PDX)
                state_reg <= ST_ACTIVE;
        end
    end
    assign cmdValid        = cmdValid_reg;
    assign cmdOut          = cmd_reg;
    assign powerDownActive = state_reg == ST_POWERDOWN;

    // open-row bookkeeping follows the issued command
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            for (int b = 0; b < NBANKS; b++) begin
                bankOpen_reg[b] <= 1'b0;
                bankRow_reg[b]  <= '0;
            end
        end else begin
            unique case (cmdNext.code)
                CMD_ACT: begin
                    bankOpen_reg[bankIdx(pl)] <= 1'b1;
                    bankRow_reg[bankIdx(pl)]  <= pl.row;
                end
                CMD_PRE: bankOpen_reg[bankIdx(pl)] <= 1'b0;
                CMD_RD, CMD_WR: begin
                    if (cmdNext.autoPre)
                        bankOpen_reg[bankIdx(pl)] <= 1'b0; // R5
                end
                CMD_PREA: begin
                    for (int b = 0; b < NBANKS; b++)
                        bankOpen_reg[b] <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            rfcWait_reg <= 8'h00;
            refiCnt_reg <= 16'h0000;
        end else begin
            if (refIssue)
                rfcWait_reg <= 8'(RFC_CYC); // R12
            else if (rfcWait_reg != 8'h00)
                rfcWait_reg <= rfcWait_reg - 8'h01;
            if (refIssue)
                refiCnt_reg <= 16'h0000; // R11
            else if (refiCnt_reg != 16'hffff)
                refiCnt_reg <= refiCnt_reg + 16'h0001;
        end
    end

    // idle means nothing queued, arriving or due on any rank
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN)
            idle_reg <= 16'h0000;
        else if (count_reg != '0 || enq || refPending
                 || state_reg == ST_POWERDOWN)
            idle_reg <= 16'h0000; // R2
        else if (idle_reg != 16'hffff)
            idle_reg <= idle_reg + 16'h0001; // R1
    end

    ////////////////////////////////////////////////////////////////////////
    property p_pd_entry;
        @(posedge ref_clk) disable iff (!rstN)
        cmdNext.code == CMD_PDE |-> count_reg == '0
            && idle_reg >= pdThr_reg && ctrl_reg[CTRL_PD_EN];
    endproperty
    a_pd_entry: assert property (p_pd_entry) // R1
        else $error("power-down entered before idle threshold");

    property p_pd_allidle;
        @(posedge ref_clk) disable iff (!rstN)
        enq |=> idle_reg == 16'h0000 ##1 cmdNext.code != CMD_PDE;
    endproperty
    a_pd_allidle: assert property (p_pd_allidle) // R2
        else $error("power-down entered while a rank was busy");

    property p_thr_range;
        @(posedge ref_clk) disable iff (!rstN)
        pdThr_reg >= PDTHR_MIN && pdThr_reg <= PDTHR_MAX;
    endproperty
    a_thr_range: assert property (p_thr_range) // R3
        else $error("idle threshold out of range");

    property p_takeover;
        @(posedge ref_clk) disable iff (!rstN)
        refIssue && ctrl_reg[CTRL_TAKEOV] |-> hostRef_reg
            ##1 !hostRef_reg || $past(busWr);
    endproperty
    a_takeover: assert property (p_takeover) // R4
        else $error("own refresh issued under host takeover");

    property p_close_page;
        @(posedge ref_clk) disable iff (!rstN)
        cmdValid_reg && cmd_reg.autoPre
            |-> !bankOpen_reg[bankIdx(cmd_reg.loc)];
    endproperty
    a_close_page: assert property (p_close_page) // R5
        else $error("bank left open after close-page access");

    property p_starve;
        @(posedge ref_clk) disable iff (!rstN)
        pickValid && qAge_reg[0] >= starve_reg && count_reg != '0
            |-> qAge_reg[pickIdx] >= starve_reg;
    endproperty
    a_starve: assert property (p_starve) // R9
        else $error("starved command passed over");

    property p_rfc;
        @(posedge ref_clk) disable iff (!rstN)
        refIssue |=> (cmdNext.code != CMD_ACT) [*8];
    endproperty
    a_rfc: assert property (p_rfc) // R12
        else $error("activate too soon after refresh");

    property p_pdx;
        @(posedge ref_clk) disable iff (!rstN)
        state_reg == ST_POWERDOWN && cmdNext.code != CMD_NOP
            |-> cmdNext.code == CMD_PDX;
    endproperty
    a_pdx: assert property (p_pdx) // R13
        else $error("command issued while powered down");

    property p_refi;
        @(posedge ref_clk) disable iff (!rstN)
        !ctrl_reg[CTRL_TAKEOV] |-> refiCnt_reg < 16'(REFI_CYC);
    endproperty
    a_refi: assert property (p_refi) // R11
        else $error("average refresh interval exceeded");

    property p_order;
        @(posedge ref_clk) disable iff (!rstN)
        deq |-> eligible[pickIdx] && pickIdx < count_reg;
    endproperty
    a_order: assert property (p_order) // R14
        else $error("access reordered past a conflicting one");
endmodule

// ### tb/ddrps_dram_model.sv
/*
 * ddr3 device model: watches the command stream, checks device timing.
 * assumes cmdValid pulses for one cycle per command on ref_clk.
 */
`timescale 1ns/1ps
module ddrps_dram_model
    import ddrps_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          cmdValid,
    input  wire ddrps_cmd_type cmdOut,
    output ddrps_cmd_type      lastRw,
    output int                 nRw,
    output int                 nRef,
    output int                 nErr
);
    int   sinceRef = 1000;
    logic inPd     = 1'b0;
    initial begin
        nRw = 0;
        nRef = 0;
        nErr = 0;
    end
    always @(posedge ref_clk) begin
        sinceRef <= sinceRef + 1;
        if (cmdValid) begin
            if (cmdOut.code == CMD_REF) begin
                nRef <= nRef + 1;
                sinceRef <= 0;
            end
            if (cmdOut.code == CMD_ACT && sinceRef < RFC_CYC - 1)
                nErr <= nErr + 1;
            if (inPd && cmdOut.code != CMD_PDX)
                nErr <= nErr + 1;
            if (cmdOut.code == CMD_PDE)
                inPd <= 1'b1;
            if (cmdOut.code == CMD_PDX)
                inPd <= 1'b0;
            if (cmdOut.code == CMD_RD || cmdOut.code == CMD_WR) begin
                lastRw <= cmdOut;
                nRw <= nRw + 1;
            end
        end
    end
endmodule

// ### tb/tb_ddrps_ctrl.sv
/*
 * testbench for the scheduler: wishbone register tasks, host requests.
 * assumes the device model sits on the command port.
 */
`timescale 1ns/1ps
module tb_ddrps_ctrl
    import ddrps_pkg::*;
;
    logic          ref_clk = 0, nrst = 0, wbCyc = 0, wbStb = 0, wbWe = 0;
    logic [3:0]    wbSel   = 4'hf;
    logic [7:0]    wbAdr   = 8'h00;
    logic [31:0]   wbDatIn = 32'h0, wbDatOut;
    logic [32:0]   q;
    logic          wbAck, reqValid = 0, reqReady, cmdValid, powerDownActive;
    ddrps_req_type reqData = '0;
    ddrps_cmd_type cmdOut, lastRw, exp;
    logic [27:0]   a;
    int            nRw, nRef, nErr, n0, n_mismatch = 0, n_checks = 0;
    ddrps_ctrl u_ddrps_ctrl (.ref_clk(ref_clk), .nrst(nrst), .wbCyc(wbCyc),
        .wbStb(wbStb), .wbWe(wbWe), .wbSel(wbSel), .wbAdr(wbAdr),
        .wbDatIn(wbDatIn), .wbAck(wbAck), .wbDatOut(wbDatOut),
        .reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
        .cmdValid(cmdValid), .cmdOut(cmdOut),
        .powerDownActive(powerDownActive));
    ddrps_dram_model u_ddrps_dram_model (.ref_clk(ref_clk),
        .cmdValid(cmdValid), .cmdOut(cmdOut), .lastRw(lastRw), .nRw(nRw),
        .nRef(nRef), .nErr(nErr));
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] ad,
                      input logic [31:0] d);
        @(posedge ref_clk);
        wbCyc <= 1;
        wbStb <= 1;
        wbWe <= we;
        wbAdr <= ad;
        wbDatIn <= d;
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        q = {1'b0, wbDatOut};
        wbCyc <= 0;
        wbStb <= 0;
    endtask
    task automatic rq(input ddrps_req_type r);
        @(posedge ref_clk);
        reqValid <= 1;
        reqData <= r;
        do @(posedge ref_clk); while (reqReady !== 1'b1);
        reqValid <= 0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1;
        repeat (4) @(posedge ref_clk);
        wb(0, REG_PDTHR, 0); chk(q, 33'h10);
        wb(0, REG_STARVE, 0); chk(q, 33'h08);
        wb(0, 8'h20, 0); chk(q, 33'h0);
        wb(1, REG_PDTHR, 32'h0); wb(0, REG_PDTHR, 0); chk(q, 33'h1);
        wb(1, REG_PDTHR, 32'hffff); wb(0, REG_PDTHR, 0); chk(q, 33'hfffe);
        wb(1, REG_STARVE, 32'h0); wb(0, REG_STARVE, 0); chk(q, 33'h1);
        wb(1, REG_STARVE, 32'h3f); wb(0, REG_STARVE, 0); chk(q, 33'h3f);
        a = 28'h9abcdef;
        for (int i = 0; i < 2; i++) begin
            wb(1, REG_CTRL, i ? 32'h24 : 32'h0);
            n0 = nRw;
            rq('{addr: a, write: i[0], closePage: 1'b1, urgent: 1'b0});
            repeat (200) if (nRw == n0) @(posedge ref_clk);
            exp.code = i ? CMD_WR : CMD_RD;
            exp.autoPre = i[0];
            exp.loc = i ? a : {a[27], a[12:10], a[26:13], a[9:0]};
            chk(lastRw, exp);
        end
        wb(1, REG_CTRL, 32'h0);
        n0 = nRef;
        repeat (REFI_CYC) @(posedge ref_clk);
        chk(33'(nRef > n0), 33'h1);
        wb(1, REG_CTRL, 32'h02);
        repeat (40) @(posedge ref_clk);
        n0 = nRef;
        repeat (2 * REFI_CYC) @(posedge ref_clk);
        chk(33'(nRef), 33'(n0));
        wb(1, REG_REFCMD, 32'h1);
        repeat (60) @(posedge ref_clk);
        chk(33'(nRef), 33'(n0 + 1));
        wb(1, REG_PDTHR, 32'd20);
        wb(1, REG_CTRL, 32'h03);
        // a host refresh is activity and restarts the idle count
        wb(1, REG_REFCMD, 32'h1);
        repeat (10) @(posedge ref_clk);
        chk({32'h0, powerDownActive}, 33'h0);
        repeat (60) if (powerDownActive !== 1'b1) @(posedge ref_clk);
        chk({32'h0, powerDownActive}, 33'h1);
        wb(0, REG_STATUS, 0); chk(q, 33'h1);
        n0 = nRw;
        rq('{addr: a, write: 1'b0, closePage: 1'b0, urgent: 1'b1});
        repeat (200) if (nRw == n0) @(posedge ref_clk);
        chk(33'(nRw), 33'(n0 + 1));
        chk(33'(nErr), 33'h0);
        finish_test();
    end
endmodule
